// ===== design/vomc_map.svh
// register offsets, field positions and reset values of the overlay control block
`ifndef VOMC_MAP_SVH
`define VOMC_MAP_SVH
`define VOMC_CTRL_OFFSET 8'h00
`define VOMC_CTRL_RESET 32'h00000000
`define VOMC_CTRL_RSVD_MASK 32'h0FFF7F7F
`define VOMC_BIT_W2_CKEY 27
`define VOMC_BIT_SEP_OUT 26
`define VOMC_BIT_IDX_FETCH 25
`define VOMC_BIT_W1_CAPT 24
`define VOMC_BIT_FIX_VINT 23
`define VOMC_BIT_ILACE_FR 22
`define VOMC_BIT_VINT 21
`define VOMC_BIT_W1_CKEY 20
`define VOMC_BIT_TOP_SEL 19
`define VOMC_GFX_FMT_LSB 16
`define VOMC_BIT_W2_DBL 14
`define VOMC_BIT_W2_HREP 13
`define VOMC_BIT_W2_AVG 12
`define VOMC_BIT_W2_EN 11
`define VOMC_W2_FMT_LSB 8
`define VOMC_BIT_W1_DBL 6
`define VOMC_BIT_W1_HREP 5
`define VOMC_BIT_W1_AVG 4
`define VOMC_BIT_W1_EN 3
`define VOMC_W1_FMT_LSB 0
`define VOMC_FIXED_VSCALE 8'h50
`define VOMC_BASE_OFFSET 32'h0040C000
`endif

// ===== design/vomc_pkg.sv
// types shared by the overlay control block
package vomc_pkg;
   typedef enum logic [2:0] {
      VOMC_FMT_IDX8 = 3'h0,
      VOMC_FMT_RGB555 = 3'h1,
      VOMC_FMT_RGB565 = 3'h2,
      VOMC_FMT_XRGB8888 = 3'h3,
      VOMC_FMT_RGB888P = 3'h4,
      VOMC_FMT_RGB332 = 3'h5,
      VOMC_FMT_YUV_A = 3'h6,
      VOMC_FMT_YUV_B = 3'h7
   } vomc_fmt_t;
   typedef struct packed {
      logic enable;
      logic colour_key_enable;
      logic horizontal_replicate;
      logic yuv_average;
      logic data_doubling;
      logic [2:0] pixel_format;
      logic is_yuv;
   } vomc_win_t;
   typedef struct packed {
      logic sel;
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } vomc_req_t;
endpackage : vomc_pkg

// ===== design/vomc_win_decode.sv
// per-window decode of enable, format and scaling bits
`timescale 1ns/1ps
module vomc_win_decode
   import vomc_pkg::*;
(
   input wire logic enable,
   input wire logic colour_key_enable,
   input wire logic horizontal_replicate,
   input wire logic yuv_average,
   input wire logic data_doubling,
   input wire logic [2:0] pixel_format,
   output vomc_win_t win
);
   // codes 11x mean yuv 4:2:2 for video windows
   wire fmt_yuv = (pixel_format[2:1] == 2'h3);
   assign win = '{enable: enable, colour_key_enable: colour_key_enable,
                  horizontal_replicate: horizontal_replicate,
                  yuv_average: yuv_average, data_doubling: data_doubling,
                  pixel_format: pixel_format, is_yuv: fmt_yuv};
endmodule : vomc_win_decode

// ===== design/vomc_ctrl.sv
// overlay miscellaneous control register and the control fan-out it drives
`timescale 1ns/1ps
`include "vomc_map.svh"
module vomc_ctrl
   import vomc_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int ADDR_BITS = 32
)
(
   input wire logic mclk,
   input wire logic sys_rst,
   input vomc_req_t req,
   output logic [31:0] rdata,
   output logic rvalid,
   input wire logic [ADDR_BITS-1:0] win1_start_reg,
   input wire logic [ADDR_BITS-1:0] capt_buf1_start,
   input wire logic [ADDR_BITS-1:0] capt_buf2_start,
   input wire logic capt_double_buffer,
   input wire logic capt_buf1_busy,
   output logic [ADDR_BITS-1:0] win1_source_start,
   output vomc_win_t win1,
   output vomc_win_t win2,
   output logic [2:0] graphics_pixel_format,
   output logic graphics_format_valid,
   output logic top_window_select,
   output logic vertical_interp_enable,
   output logic fixed_vertical_interp_enable,
   output logic [7:0] vertical_scale_fixed,
   output logic interlace_flicker_reduce,
   output logic separate_output_enable,
   output logic index_fetch_via_video_fifo,
   output logic win1_source_from_capture,
   output logic single_window_violation,
   output logic first_video_fifo_pace,
   output logic second_video_fifo_pace
);
   logic [31:0] misc_overlay_control;
   logic [31:0] next_misc_overlay_control;
   logic [ADDR_BITS-1:0] next_win1_source_start;
   logic pace1;
   logic pace2;
   logic [31:0] next_rdata;

   // address decode; the window of this block sits at base plus the fixed offset
   wire hit = req.sel && (req.addr == `VOMC_CTRL_OFFSET);
   wire do_wr = hit && req.wr;
   wire do_rd = req.sel && req.rd;

   // reserved bits are masked on write so they never steer anything
   assign next_misc_overlay_control = do_wr ? (req.wdata & `VOMC_CTRL_RSVD_MASK)
                                            : misc_overlay_control;

   // register read returns zero for unmapped offsets and reserved bits
   assign next_rdata = hit ? (misc_overlay_control & `VOMC_CTRL_RSVD_MASK) : 32'h00000000;

   // control register storage
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         misc_overlay_control <= `VOMC_CTRL_RESET;
      end else begin
         misc_overlay_control <= next_misc_overlay_control;
      end
   end

   // read data from flops, one cycle after the strobe
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rdata <= 32'h00000000;
         rvalid <= 1'b0;
      end else begin
         rdata <= do_rd ? next_rdata : rdata;
         rvalid <= do_rd;
      end
   end

   // global controls fan out straight from the register bits
   assign separate_output_enable = misc_overlay_control[`VOMC_BIT_SEP_OUT];
   assign index_fetch_via_video_fifo = misc_overlay_control[`VOMC_BIT_IDX_FETCH];
   assign win1_source_from_capture = misc_overlay_control[`VOMC_BIT_W1_CAPT];
   assign fixed_vertical_interp_enable = misc_overlay_control[`VOMC_BIT_FIX_VINT];
   assign vertical_scale_fixed = fixed_vertical_interp_enable ? `VOMC_FIXED_VSCALE
                                                              : 8'h00;
   assign interlace_flicker_reduce = misc_overlay_control[`VOMC_BIT_ILACE_FR];
   assign vertical_interp_enable = misc_overlay_control[`VOMC_BIT_VINT];
   assign top_window_select = misc_overlay_control[`VOMC_BIT_TOP_SEL];
   assign graphics_pixel_format = misc_overlay_control[`VOMC_GFX_FMT_LSB +: 3];
   // 11x are reserved graphics codes; flagged so the pipe can ignore them
   assign graphics_format_valid = (graphics_pixel_format[2:1] != 2'h3);

   // software may not enable both windows with these features; flag it only
   assign single_window_violation = (interlace_flicker_reduce || vertical_interp_enable)
                                    && win1.enable && win2.enable;

   // window one fields
   vomc_win_decode u_win1 (
      .enable(misc_overlay_control[`VOMC_BIT_W1_EN]),
      .colour_key_enable(misc_overlay_control[`VOMC_BIT_W1_CKEY]),
      .horizontal_replicate(misc_overlay_control[`VOMC_BIT_W1_HREP]),
      .yuv_average(misc_overlay_control[`VOMC_BIT_W1_AVG]),
      .data_doubling(misc_overlay_control[`VOMC_BIT_W1_DBL]),
      .pixel_format(misc_overlay_control[`VOMC_W1_FMT_LSB +: 3]),
      .win(win1)
   );

   // window two fields
   vomc_win_decode u_win2 (
      .enable(misc_overlay_control[`VOMC_BIT_W2_EN]),
      .colour_key_enable(misc_overlay_control[`VOMC_BIT_W2_CKEY]),
      .horizontal_replicate(misc_overlay_control[`VOMC_BIT_W2_HREP]),
      .yuv_average(misc_overlay_control[`VOMC_BIT_W2_AVG]),
      .data_doubling(misc_overlay_control[`VOMC_BIT_W2_DBL]),
      .pixel_format(misc_overlay_control[`VOMC_W2_FMT_LSB +: 3]),
      .win(win2)
   );

   // window one start address select; double buffer swaps away from busy buffer
   assign next_win1_source_start =
      !win1_source_from_capture ? win1_start_reg :
      (capt_double_buffer && capt_buf1_busy) ? capt_buf2_start :
      capt_buf1_start;

   // registered so the fetch side sees a stable address
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         win1_source_start <= '0;
      end else begin
         win1_source_start <= next_win1_source_start;
      end
   end

   // fifo pacing: with doubling the fifo shifts on every other clock only;
   // paced on mclk here, the video clock pipe rescales as needed
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pace1 <= 1'b0;
         pace2 <= 1'b0;
      end else begin
         pace1 <= win1.data_doubling ? !pace1 : 1'b0;
         pace2 <= win2.data_doubling ? !pace2 : 1'b0;
      end
   end
   assign first_video_fifo_pace = win1.data_doubling ? pace1 : 1'b1;
   assign second_video_fifo_pace = win2.data_doubling ? pace2 : 1'b1;

   // assertions on the register and its fan-out
   // bus steps as seen at the taking edge
   sequence s_write_ctrl;
      req.sel && req.wr && (req.addr == `VOMC_CTRL_OFFSET);
   endsequence

   sequence s_read_ctrl;
      req.sel && req.rd && !req.wr && (req.addr == `VOMC_CTRL_OFFSET);
   endsequence

   sequence s_write_other;
      req.sel && req.wr && (req.addr != `VOMC_CTRL_OFFSET);
   endsequence

   sequence s_read_other;
      req.sel && req.rd && (req.addr != `VOMC_CTRL_OFFSET);
   endsequence

   // capture-sourced display, single buffer and the busy swap
   sequence s_capt_single;
      win1_source_from_capture && !capt_double_buffer;
   endsequence

   sequence s_capt_swap;
      win1_source_from_capture && capt_double_buffer && capt_buf1_busy;
   endsequence

   a_reset_zero: assert property (@(posedge mclk)
      sys_rst |=> misc_overlay_control == `VOMC_CTRL_RESET)
      else $error("control not zero after reset");

   a_reset_outputs: assert property (@(posedge mclk)
      sys_rst |=> !win1.enable && !win2.enable && !rvalid && rdata == 32'h00000000
                  && first_video_fifo_pace && second_video_fifo_pace)
      else $error("outputs not idle after reset");

   a_write_stores: assert property (@(posedge mclk) disable iff (sys_rst)
      s_write_ctrl |=> misc_overlay_control == ($past(req.wdata) & `VOMC_CTRL_RSVD_MASK))
      else $error("control write not stored");

   a_reserved_read_zero: assert property (@(posedge mclk) disable iff (sys_rst)
      rvalid |-> (rdata & ~`VOMC_CTRL_RSVD_MASK) == 32'h00000000)
      else $error("reserved bits read nonzero");

   a_read_returns: assert property (@(posedge mclk) disable iff (sys_rst)
      s_read_ctrl |=> rvalid && rdata == $past(misc_overlay_control))
      else $error("read data wrong");

   a_read_other_zero: assert property (@(posedge mclk) disable iff (sys_rst)
      s_read_other |=> rvalid && rdata == 32'h00000000)
      else $error("unmapped read not zero");

   a_write_other_kept: assert property (@(posedge mclk) disable iff (sys_rst)
      s_write_other |=> $stable(misc_overlay_control))
      else $error("unmapped write changed control");

   a_rvalid_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
      do_rd |=> rvalid)
      else $error("read not answered");

   a_rvalid_idle: assert property (@(posedge mclk) disable iff (sys_rst)
      !do_rd |=> !rvalid)
      else $error("answer without read");

   a_rdata_hold: assert property (@(posedge mclk) disable iff (sys_rst)
      !do_rd |=> $stable(rdata))
      else $error("read data moved without read");

   a_capt_single: assert property (@(posedge mclk) disable iff (sys_rst)
      s_capt_single |=> win1_source_start == $past(capt_buf1_start))
      else $error("single buffer source wrong");

   a_capt_double: assert property (@(posedge mclk) disable iff (sys_rst)
      s_capt_swap |=> win1_source_start == $past(capt_buf2_start))
      else $error("double buffer source wrong");

   a_reg_source: assert property (@(posedge mclk) disable iff (sys_rst)
      !win1_source_from_capture |=> win1_source_start == $past(win1_start_reg))
      else $error("register source wrong");

   a_capt_select: assert property (@(posedge mclk) disable iff (sys_rst)
      s_write_ctrl |=> win1_source_from_capture == $past(req.wdata[`VOMC_BIT_W1_CAPT]))
      else $error("capture select not from write");

   a_fixed_scale: assert property (@(posedge mclk) disable iff (sys_rst)
      misc_overlay_control[`VOMC_BIT_FIX_VINT] |-> vertical_scale_fixed == 8'h50)
      else $error("fixed scale not 80");

   a_scale_off: assert property (@(posedge mclk) disable iff (sys_rst)
      !misc_overlay_control[`VOMC_BIT_FIX_VINT] |-> vertical_scale_fixed == 8'h00)
      else $error("fixed scale shown while off");

   a_fix_vint: assert property (@(posedge mclk) disable iff (sys_rst)
      s_write_ctrl |=> fixed_vertical_interp_enable == $past(req.wdata[`VOMC_BIT_FIX_VINT]))
      else $error("fixed interpolation not from write");

   a_w2_ckey: assert property (@(posedge mclk) disable iff (sys_rst)
      s_write_ctrl |=> win2.colour_key_enable == $past(req.wdata[`VOMC_BIT_W2_CKEY]))
      else $error("window two key enable wrong");

   a_w1_ckey: assert property (@(posedge mclk) disable iff (sys_rst)
      s_write_ctrl |=> win1.colour_key_enable == $past(req.wdata[`VOMC_BIT_W1_CKEY]))
      else $error("window one key enable wrong");

   a_sep_out: assert property (@(posedge mclk) disable iff (sys_rst)
      s_write_ctrl |=> separate_output_enable == $past(req.wdata[`VOMC_BIT_SEP_OUT]))
      else $error("separate output not from write");

   a_idx_fetch: assert property (@(posedge mclk) disable iff (sys_rst)
      s_write_ctrl |=> index_fetch_via_video_fifo == $past(req.wdata[`VOMC_BIT_IDX_FETCH]))
      else $error("index fetch not from write");

   a_ilace: assert property (@(posedge mclk) disable iff (sys_rst)
      s_write_ctrl |=> interlace_flicker_reduce == $past(req.wdata[`VOMC_BIT_ILACE_FR]))
      else $error("flicker reduce not from write");

   a_vint: assert property (@(posedge mclk) disable iff (sys_rst)
      s_write_ctrl |=> vertical_interp_enable == $past(req.wdata[`VOMC_BIT_VINT]))
      else $error("vertical interpolation not from write");

   a_single_window: assert property (@(posedge mclk) disable iff (sys_rst)
      (interlace_flicker_reduce || vertical_interp_enable) && win1.enable && win2.enable
      |-> single_window_violation)
      else $error("two windows not flagged");

   a_single_ok: assert property (@(posedge mclk) disable iff (sys_rst)
      !(win1.enable && win2.enable) |-> !single_window_violation)
      else $error("single window flagged");

   a_top_select: assert property (@(posedge mclk) disable iff (sys_rst)
      s_write_ctrl |=> top_window_select == $past(req.wdata[`VOMC_BIT_TOP_SEL]))
      else $error("top select not from write");

   a_gfx_format: assert property (@(posedge mclk) disable iff (sys_rst)
      s_write_ctrl |=> graphics_pixel_format == $past(req.wdata[`VOMC_GFX_FMT_LSB +: 3]))
      else $error("graphics format not from write");

   a_gfx_valid: assert property (@(posedge mclk) disable iff (sys_rst)
      graphics_format_valid == (graphics_pixel_format <= 3'h5))
      else $error("graphics format validity wrong");

   a_hrep_bits: assert property (@(posedge mclk) disable iff (sys_rst)
      s_write_ctrl |=> win1.horizontal_replicate == $past(req.wdata[`VOMC_BIT_W1_HREP])
                       && win2.horizontal_replicate == $past(req.wdata[`VOMC_BIT_W2_HREP]))
      else $error("replication bits wrong");

   a_yuv_avg: assert property (@(posedge mclk) disable iff (sys_rst)
      s_write_ctrl |=> win1.yuv_average == $past(req.wdata[`VOMC_BIT_W1_AVG])
                       && win2.yuv_average == $past(req.wdata[`VOMC_BIT_W2_AVG]))
      else $error("averaging bits wrong");

   a_win_enable: assert property (@(posedge mclk) disable iff (sys_rst)
      s_write_ctrl |=> win2.enable == $past(req.wdata[`VOMC_BIT_W2_EN])
                       && win1.enable == $past(req.wdata[`VOMC_BIT_W1_EN]))
      else $error("window enables not from write");

   a_win_format: assert property (@(posedge mclk) disable iff (sys_rst)
      s_write_ctrl |=> win1.pixel_format == $past(req.wdata[`VOMC_W1_FMT_LSB +: 3])
                       && win2.pixel_format == $past(req.wdata[`VOMC_W2_FMT_LSB +: 3]))
      else $error("window formats not from write");

   a_yuv_code: assert property (@(posedge mclk) disable iff (sys_rst)
      win2.is_yuv == (misc_overlay_control[10:9] == 2'h3))
      else $error("window two yuv decode wrong");

   a_dbl_bits: assert property (@(posedge mclk) disable iff (sys_rst)
      s_write_ctrl |=> win1.data_doubling == $past(req.wdata[`VOMC_BIT_W1_DBL])
                       && win2.data_doubling == $past(req.wdata[`VOMC_BIT_W2_DBL]))
      else $error("doubling bits wrong");

   a_pace_half: assert property (@(posedge mclk) disable iff (sys_rst)
      (win1.data_doubling && first_video_fifo_pace) ##1 win1.data_doubling
      |-> !first_video_fifo_pace)
      else $error("window one fifo paced too fast");

   a_pace2_half: assert property (@(posedge mclk) disable iff (sys_rst)
      (win2.data_doubling && second_video_fifo_pace) ##1 win2.data_doubling
      |-> !second_video_fifo_pace)
      else $error("window two fifo paced too fast");

   a_pace_rate: assert property (@(posedge mclk) disable iff (sys_rst)
      (win1.data_doubling && !first_video_fifo_pace) ##1 win1.data_doubling
      |-> first_video_fifo_pace)
      else $error("window one fifo stalled");

   a_pace2_rate: assert property (@(posedge mclk) disable iff (sys_rst)
      (win2.data_doubling && !second_video_fifo_pace) ##1 win2.data_doubling
      |-> second_video_fifo_pace)
      else $error("window two fifo stalled");

   a_pace_full: assert property (@(posedge mclk) disable iff (sys_rst)
      !win1.data_doubling |-> first_video_fifo_pace)
      else $error("window one fifo paced without doubling");

   a_pace2_full: assert property (@(posedge mclk) disable iff (sys_rst)
      !win2.data_doubling |-> second_video_fifo_pace)
      else $error("window two fifo paced without doubling");
endmodule : vomc_ctrl

// ===== dv/vomc_host_model.sv
// host software model issuing single-word register requests
`timescale 1ns/1ps
module vomc_host_model
   import vomc_pkg::*;
(
   input wire logic mclk,
   output vomc_req_t req,
   input wire logic [31:0] rdata,
   input wire logic rvalid
);
   initial req = '0;

   // hold until the taking edge, then drop select and scramble the idle bus
   task automatic write_reg(input logic [7:0] addr, input logic [31:0] data);
      @(posedge mclk);
      req <= '{sel: 1'b1, wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
      @(posedge mclk);
      req <= '{sel: 1'b0, wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
   endtask : write_reg

   // answer pulses for one cycle only, so it is sampled right after the edge
   task automatic read_reg(input logic [7:0] addr, output logic [31:0] data, output logic ok);
      @(posedge mclk);
      req <= '{sel: 1'b1, wr: 1'b0, rd: 1'b1, addr: addr, wdata: 32'h0};
      @(posedge mclk);
      req <= '{sel: 1'b0, wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 32'hFFFFFFFF};
      #1;
      data = rdata;
      ok = rvalid;
   endtask : read_reg
endmodule : vomc_host_model

// ===== dv/video_overlay_misc_control_tb_top.sv
// self-checking bench for the overlay control register block
`timescale 1ns/1ps
module video_overlay_misc_control_tb_top
   import vomc_pkg::*;
;
   logic mclk, sys_rst, rvalid, dbl, busy, ok, prev;
   vomc_req_t req;
   logic [31:0] rdata, w1s, b1, b2, w1src, rd_v;
   vomc_win_t win1, win2;
   logic [2:0] gfmt;
   logic gvalid, top_sel, vint, fvint, ilace, sep, idxf, capt, viol, p1, p2;
   logic [7:0] vscale;
   int bad_count, cmp_count, cyc;
   logic [31:0] cap_ctrl [4] = '{32'h0, 32'h01000000, 32'h01000000, 32'h01000000};
   logic [1:0] cap_st [4] = '{2'h3, 2'h1, 2'h3, 2'h2};

   vomc_host_model host (.mclk(mclk), .req(req), .rdata(rdata), .rvalid(rvalid));

   vomc_ctrl uut (.mclk(mclk), .sys_rst(sys_rst), .req(req), .rdata(rdata), .rvalid(rvalid),
      .win1_start_reg(w1s), .capt_buf1_start(b1), .capt_buf2_start(b2),
      .capt_double_buffer(dbl), .capt_buf1_busy(busy), .win1_source_start(w1src),
      .win1(win1), .win2(win2), .graphics_pixel_format(gfmt), .graphics_format_valid(gvalid),
      .top_window_select(top_sel), .vertical_interp_enable(vint),
      .fixed_vertical_interp_enable(fvint), .vertical_scale_fixed(vscale),
      .interlace_flicker_reduce(ilace), .separate_output_enable(sep),
      .index_fetch_via_video_fifo(idxf), .win1_source_from_capture(capt),
      .single_window_violation(viol), .first_video_fifo_pace(p1), .second_video_fifo_pace(p2));

   // compare with four-state equality so unknowns never match
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      host.read_reg(a, rd_v, ok);
      chk(ok, 1, "read answer");
      chk(rd_v, exp, what);
   endtask : rd

   task automatic close_out;
      if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : close_out

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // hang guard, far above the sixty or so cycles the sequence needs
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         $display("[ERR] %0t timeout", $time);
         close_out();
      end
   end

   initial begin
      sys_rst = 1'b1;
      w1s = 32'h00001000;
      b1 = 32'h00002000;
      b2 = 32'h00003000;
      dbl = 1'b0;
      busy = 1'b0;
      repeat (6) @(posedge mclk);
      sys_rst <= 1'b0;
      rd(8'h00, 32'h0, "reset value");
      chk({win1.enable, win2.enable, vscale, p1, p2}, 12'h003, "reset outputs");
      // all ones: reserved bits drop, software breaks the one-window limit on purpose
      host.write_reg(8'h00, 32'hFFFFFFFF);
      #1;
      chk({win2.colour_key_enable, sep, idxf, capt, fvint, ilace, vint,
         win1.colour_key_enable, top_sel}, 9'h1FF, "ctrl ones");
      chk({vscale, viol, gfmt, gvalid}, 13'h0A1E, "scale fmt");
      chk({win1, win2}, 18'h3FFFF, "win ones");
      prev = p1;
      repeat (4) begin
         @(posedge mclk);
         #1;
         chk({p1, p2}, {~prev, ~prev}, "fifo pace");
         prev = p1;
      end
      rd(8'h00, 32'h0FFF7F7F, "reserved read");
      // mixed pattern catches swapped bits; single window kept for vint
      host.write_reg(8'h00, 32'h0A2A2E15);
      #1;
      chk({win2.colour_key_enable, sep, idxf, capt, fvint, ilace, vint,
         win1.colour_key_enable, top_sel}, 9'h145, "ctrl mix");
      chk({vscale, viol, gfmt, gvalid, p1, p2}, 15'h0017, "mix misc");
      chk({win1, win2}, {9'h02A, 9'h1CD}, "win mix");
      for (int i = 0; i < 8; i++) begin
         host.write_reg(8'h00, {13'h0, i[2:0], 5'h0, i[2:0], 5'h0, i[2:0]});
         #1;
         chk({gfmt, gvalid}, {i[2:0], i < 6}, "gfx format");
         chk({win1.pixel_format, win1.is_yuv, win2.is_yuv}, {i[2:0], i >= 6, i >= 6},
            "win format");
      end
      // capture sourcing: bit clear, single, double busy, double idle
      for (int i = 0; i < 4; i++) begin
         host.write_reg(8'h00, cap_ctrl[i]);
         dbl <= cap_st[i][1];
         busy <= cap_st[i][0];
         repeat (2) @(posedge mclk);
         #1;
         chk(w1src, (i == 0) ? w1s : (i == 2) ? b2 : b1, "win1 source");
      end
      // only offset zero is mapped
      host.write_reg(8'h04, 32'hFFFFFFFF);
      rd(8'h00, 32'h01000000, "unmapped write");
      rd(8'h04, 32'h0, "unmapped read");
      close_out();
   end
endmodule : video_overlay_misc_control_tb_top
